// File: core/cmp_output_conditioning.sv
// Two-channel digital conditioning of analog comparator outputs.
//
// Overview of operation
// - Filter and edge register at F0341H, byte access, resets to 00H.
// - Edge select bit: 0 one-edge, 1 both-edge detection for requests.
// - Polarity bit: 0 rising edge fires, 1 falling edge fires.
// - Filter field: 00 none, 01 every clock, 10 clock/8, 11 clock/32.
// - Channel 0 uses the low nibble with the same field layout.
// - Output control register at F0342H, resets to 00H.
// - Output invert bit passes result straight or inverted.
// - Output gate bit forces cutoff output low when clear.
// - Interrupt enable bit blocks the channel interrupt request when clear.
// - Invert and gate steer only the cutoff path, never port pins.
// - Read-only monitor flag shows the synchronised comparator level, ahead of the noise filter.
`timescale 1ns/1ps
`default_nettype none
module cmp_output_conditioning
	import cmp_cond_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output var  logic [DATA_W-1:0] regRdData,
	input  wire logic [NUM_CH-1:0] cmpResult,
	output var  logic [NUM_CH-1:0] cutoffOut,
	output var  logic [NUM_CH-1:0] eventOut,
	output var  logic              irqOut
);

	// Picks the active edge from the edge select and polarity settings.
	function automatic logic edge_hit(input logic rise, input logic fall,
		input logic bothEdge, input logic fallEdge);
		if (bothEdge) begin
			return rise | fall;
		end
		return fallEdge ? fall : rise;
	endfunction

	// Register file.
	logic [7:0] filterEdge_ff;
	logic [7:0] outputControl_ff;
	logic [7:0] irqStatus_ff;
	logic [7:0] irqMask_ff;
	logic [7:0] regRdData_ff;
	logic [7:0] nxt_irqStatus;
	logic [7:0] nxt_regRdData;

	wire logic selFilterEdge;
	wire logic selOutputControl;
	wire logic selIrqStatus;
	wire logic selIrqMask;
	wire logic selMonitor;

	assign selFilterEdge    = regAddr == FILTER_EDGE_ADDR;
	assign selOutputControl = regAddr == OUTPUT_CONTROL_ADDR;
	assign selIrqStatus     = regAddr == IRQ_STATUS_ADDR;
	assign selIrqMask       = regAddr == IRQ_MASK_ADDR;
	assign selMonitor       = regAddr == MONITOR_ADDR;

	// Comparator input synchroniser, three stages.
	logic [NUM_CH-1:0] syncA_ff;
	logic [NUM_CH-1:0] syncB_ff;
	logic [NUM_CH-1:0] syncC_ff;
	logic [NUM_CH-1:0] cmpLevel_ff;
	wire  logic [NUM_CH-1:0] nxt_cmpLevel;

	// A change only counts once the second and third stage agree.
	assign nxt_cmpLevel = (syncB_ff & syncC_ff)
		| (cmpLevel_ff & (syncB_ff | syncC_ff));

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			syncA_ff    <= '0;
			syncB_ff    <= '0;
			syncC_ff    <= '0;
			cmpLevel_ff <= '0;
		end else begin
			syncA_ff    <= cmpResult;
			syncB_ff    <= syncA_ff;
			syncC_ff    <= syncB_ff;
			cmpLevel_ff <= nxt_cmpLevel;
		end
	end

	// Sample rate divider shared by both channels.
	logic [4:0] divCount_ff;
	wire  logic div8Tick;
	wire  logic div32Tick;

	assign div8Tick  = divCount_ff[2:0] == 3'(DIV8_COUNT - 1);
	assign div32Tick = divCount_ff == 5'(DIV32_COUNT - 1);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCount_ff <= 5'h00;
		end else begin
			divCount_ff <= divCount_ff + 5'h01;
		end
	end

	// Per-channel conditioning.
	logic [NUM_CH-1:0] filtPrev_ff;
	logic [NUM_CH-1:0] cutoffOut_ff;
	logic [NUM_CH-1:0] eventOut_ff;
	wire  logic [NUM_CH-1:0] filtLevel;
	wire  logic [NUM_CH-1:0] chEdge;
	wire  logic [NUM_CH-1:0] chIrqReq;
	wire  logic [NUM_CH-1:0] nxt_cutoffOut;

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		localparam int unsigned FB = ch * CH_NIBBLE;
		wire filter_rate_t rate;
		wire logic         sampleEn;
		wire logic         bothEdge;
		wire logic         fallEdge;
		wire logic         invert;
		wire logic         gate;
		wire logic         irqEn;
		wire logic         rise;
		wire logic         fall;

		// Channel 1 uses the high nibble, channel 0 the low one.
		assign rate = filter_rate_t'(filterEdge_ff[FB+RATE_LSB +: 2]);
		assign bothEdge = filterEdge_ff[FB+BOTH_EDGE_BIT];
		assign fallEdge = filterEdge_ff[FB+FALL_EDGE_BIT];
		assign invert   = outputControl_ff[FB+INVERT_BIT];
		assign gate     = outputControl_ff[FB+GATE_BIT];
		assign irqEn    = outputControl_ff[FB+IRQ_EN_BIT];

		// Sample strobe picked from the filter field.
		assign sampleEn = (rate == RATE_DIV1)
			| ((rate == RATE_DIV8) & div8Tick)
			| ((rate == RATE_DIV32) & div32Tick);

		cmp_noise_filter #(
			.AGREE (AGREE_COUNT)
		) u_filter (
			.ref_clk  (ref_clk),
			.reset_n  (reset_n),
			.bypass   (rate == RATE_BYPASS),
			.sampleEn (sampleEn),
			.levelIn  (cmpLevel_ff[ch]),
			.levelOut (filtLevel[ch])
		);

		assign rise = filtLevel[ch] & ~filtPrev_ff[ch];
		assign fall = ~filtLevel[ch] & filtPrev_ff[ch];
		// Rewriting the edge fields cannot fake an edge; only filtered level changes count.
		assign chEdge[ch] = edge_hit(rise, fall, bothEdge, fallEdge);
		assign chIrqReq[ch] = chEdge[ch] & irqEn;
		// The cutoff path is the only consumer of invert and gate.
		assign nxt_cutoffOut[ch] = gate & (filtLevel[ch] ^ invert);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			filtPrev_ff  <= '0;
			cutoffOut_ff <= '0;
			eventOut_ff  <= '0;
		end else begin
			filtPrev_ff  <= filtLevel;
			cutoffOut_ff <= nxt_cutoffOut;
			eventOut_ff  <= chEdge;
		end
	end

	// Register writes.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			filterEdge_ff <= FILTER_EDGE_RST;
		end else if (regWrite && selFilterEdge) begin
			filterEdge_ff <= regWrData;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			outputControl_ff <= OUTPUT_CONTROL_RST;
		end else if (regWrite && selOutputControl) begin
			outputControl_ff <= regWrData & OUTPUT_CONTROL_WMASK;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqMask_ff <= IRQ_MASK_RST;
		end else if (regWrite && selIrqMask) begin
			irqMask_ff <= {6'h00, regWrData[NUM_CH-1:0]};
		end
	end

	// Sticky status: write one clears, a new request in the same cycle wins.
	always_comb begin
		nxt_irqStatus = irqStatus_ff;
		if (regWrite && selIrqStatus) begin
			nxt_irqStatus = irqStatus_ff & ~regWrData;
		end
		nxt_irqStatus[NUM_CH-1:0] = nxt_irqStatus[NUM_CH-1:0] | chIrqReq;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStatus_ff <= IRQ_STATUS_RST;
		end else begin
			irqStatus_ff <= nxt_irqStatus;
		end
	end

	logic irqOut_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqOut_ff <= 1'b0;
		end else begin
			irqOut_ff <= |(nxt_irqStatus & irqMask_ff);
		end
	end

	// Read path: data stand in the cycle after the strobe only.
	wire logic [7:0] monitorValue;

	assign monitorValue = {6'h00, cmpLevel_ff};

	always_comb begin
		nxt_regRdData = READ_UNMAPPED;
		if (regRead) begin
			if (selFilterEdge) begin
				nxt_regRdData = filterEdge_ff;
			end else if (selOutputControl) begin
				nxt_regRdData = outputControl_ff;
			end else if (selIrqStatus) begin
				nxt_regRdData = irqStatus_ff;
			end else if (selIrqMask) begin
				nxt_regRdData = irqMask_ff;
			end else if (selMonitor) begin
				nxt_regRdData = monitorValue;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData_ff <= READ_UNMAPPED;
		end else begin
			regRdData_ff <= nxt_regRdData;
		end
	end

	assign regRdData = regRdData_ff;
	assign cutoffOut = cutoffOut_ff;
	assign eventOut  = eventOut_ff;
	assign irqOut    = irqOut_ff;

endmodule
`default_nettype wire

// File: core/cmp_cond_pkg.sv
// Package with register map, field layout and timing constants of the block.
package cmp_cond_pkg;

	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_CH = 2;

	// Documented register addresses.
	localparam logic [19:0] FILTER_EDGE_ADDR    = 20'hf0341;
	localparam logic [19:0] OUTPUT_CONTROL_ADDR = 20'hf0342;
	// Interrupt status, mask and comparator monitor registers.
	localparam logic [19:0] IRQ_STATUS_ADDR     = 20'hf0348;
	localparam logic [19:0] IRQ_MASK_ADDR       = 20'hf0349;
	localparam logic [19:0] MONITOR_ADDR        = 20'hf034a;

	localparam logic [7:0] FILTER_EDGE_RST    = 8'h00;
	localparam logic [7:0] OUTPUT_CONTROL_RST = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RST     = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST       = 8'h00;
	localparam logic [7:0] READ_UNMAPPED      = 8'h00;

	// Each channel owns one nibble; channel 1 sits in the high nibble.
	localparam int unsigned CH_NIBBLE     = 4;
	localparam int unsigned BOTH_EDGE_BIT = 3;
	localparam int unsigned FALL_EDGE_BIT = 2;
	localparam int unsigned RATE_LSB      = 0;
	localparam int unsigned INVERT_BIT    = 2;
	localparam int unsigned GATE_BIT      = 1;
	localparam int unsigned IRQ_EN_BIT    = 0;
	// Bits 7 and 3 of the output control register are reserved zeros.
	localparam logic [7:0] OUTPUT_CONTROL_WMASK = 8'h77;

	typedef enum logic [1:0] {
		RATE_BYPASS = 2'b00,
		RATE_DIV1   = 2'b01,
		RATE_DIV8   = 2'b10,
		RATE_DIV32  = 2'b11
	} filter_rate_t;

	localparam int unsigned DIV8_COUNT   = 8;
	localparam int unsigned DIV32_COUNT  = 32;
	localparam int unsigned AGREE_COUNT  = 4;

endpackage

// File: core/cmp_noise_filter.sv
// Noise filter for one comparator channel with four-sample agreement.
`timescale 1ns/1ps
`default_nettype none
module cmp_noise_filter
	import cmp_cond_pkg::*;
#(
	parameter int unsigned AGREE = AGREE_COUNT
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic bypass,
	input  wire logic sampleEn,
	input  wire logic levelIn,
	output var  logic levelOut
);

	logic [AGREE-1:0] history_ff;
	logic [AGREE-1:0] nxt_history;
	logic             levelOut_ff;
	logic             nxt_levelOut;
	wire  logic [AGREE-1:0] shifted;
	wire  logic       allHigh;
	wire  logic       allLow;

	// The vote looks at the history including this sample, taken from the
	// flops so that the combinational block never feeds back into itself.
	assign shifted = {history_ff[AGREE-2:0], levelIn};
	assign allHigh = &shifted;
	assign allLow  = ~|shifted;

	// In bypass the history is flooded so a switch to filtering starts clean.
	always_comb begin
		nxt_history  = history_ff;
		nxt_levelOut = levelOut_ff;
		if (bypass) begin
			nxt_history  = {AGREE{levelIn}};
			nxt_levelOut = levelIn;
		end else if (sampleEn) begin
			nxt_history = shifted;
			if (allHigh) begin
				nxt_levelOut = 1'b1;
			end else if (allLow) begin
				nxt_levelOut = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			history_ff  <= '0;
			levelOut_ff <= 1'b0;
		end else begin
			history_ff  <= nxt_history;
			levelOut_ff <= nxt_levelOut;
		end
	end

	assign levelOut = levelOut_ff;

endmodule
`default_nettype wire

// File: dv/cmp_cond_chk.sv
// Checker with concurrent assertions on the conditioning block's ports.
`timescale 1ns/1ps
`default_nettype none
module cmp_cond_chk
	import cmp_cond_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              reset_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic [NUM_CH-1:0] cmpResult,
	input wire logic [NUM_CH-1:0] cutoffOut,
	input wire logic [NUM_CH-1:0] eventOut,
	input wire logic              irqOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] fe_ff;
	logic [7:0] ctl_ff;
	logic [1:0] msk_ff;
	logic [6:0] hist_ff;
	logic [3:0] quiet_ff;
	// Exact timing is only claimed in bypass, eight cycles after the last register write.
	wire byp  = quiet_ff >= 4'h8 && fe_ff[1:0] == 2'b00;
	// The raw input reaches the registered outputs six edges later.
	wire rise = hist_ff[5] & ~hist_ff[6];
	wire fall = ~hist_ff[5] & hist_ff[6];
	wire expEvt = fe_ff[3] ? (rise | fall) : (fe_ff[2] ? fall : rise);
	wire expCut = ctl_ff[1] & (ctl_ff[2] ^ hist_ff[5]);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fe_ff <= 8'h00;
			ctl_ff <= 8'h00;
			msk_ff <= 2'b00;
			hist_ff <= 7'h00;
			quiet_ff <= 4'h0;
		end else begin
			if (regWrite && regAddr == FILTER_EDGE_ADDR)
				fe_ff <= regWrData;
			if (regWrite && regAddr == OUTPUT_CONTROL_ADDR)
				ctl_ff <= regWrData & OUTPUT_CONTROL_WMASK;
			if (regWrite && regAddr == IRQ_MASK_ADDR)
				msk_ff <= regWrData[1:0];
			hist_ff <= {hist_ff[5:0], cmpResult[0]};
			if (regWrite)
				quiet_ff <= 4'h0;
			else if (quiet_ff != 4'hf)
				quiet_ff <= quiet_ff + 4'h1;
		end
	end
	rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside read slot");
	rd_filt_a: assert property (regRead && regAddr == FILTER_EDGE_ADDR
		|=> regRdData == fe_ff) else $error("filter register readback");
	rd_ctl_a: assert property (regRead && regAddr == OUTPUT_CONTROL_ADDR
		|=> regRdData == ctl_ff) else $error("output control readback");
	evt_edge_a: assert property (byp |-> eventOut[0] == expEvt)
		else $error("event does not match edge mode");
	cut_path_a: assert property (byp |-> cutoffOut[0] == expCut)
		else $error("cutoff output wrong");
	gate_low_a: assert property (!ctl_ff[5] && !$past(ctl_ff[5])
		|-> !cutoffOut[1]) else $error("gated cutoff not low");
	evt_pulse_a: assert property (eventOut[1] |=> !eventOut[1])
		else $error("event longer than one cycle");
	irq_mask_a: assert property (msk_ff == 2'b00 && $past(msk_ff) == 2'b00
		|-> !irqOut) else $error("interrupt while masked");
	irq_cause_a: assert property ($rose(irqOut) |-> (|eventOut)
		|| $past(regWrite) || $past(regWrite, 2)) else $error("irq no cause");
	cover property (byp && eventOut[0]);
	cover property ($rose(irqOut));
	cover property (cutoffOut == 2'b11 && fe_ff[1:0] != 2'b00);
endmodule
bind cmp_output_conditioning cmp_cond_chk cmp_cond_chk_i (.ref_clk, .reset_n,
	.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .cmpResult,
	.cutoffOut, .eventOut, .irqOut);
`default_nettype wire

// File: dv/cmp_analog_model.sv
// Behavioural model of the two analog comparators feeding the block.
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model #(
	parameter int SETTLE = 1
) (
	input  wire logic [1:0] level,
	output var  logic [1:0] cmpResult
);
	// A high level means the input sits above its reference voltage.
	initial cmpResult = 2'b00;
	always @(level) cmpResult <= #(SETTLE) level;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the comparator output conditioning block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import cmp_cond_pkg::*;
;
	logic              ref_clk, reset_n, regWrite, regRead, rdSeen, irqOut;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData, fe;
	logic [NUM_CH-1:0] level, cmpResult, cutoffOut, eventOut;
	int                miscompares, n_compared, evtCnt, p, r;
	logic [7:0]        expQ[$];
	cmp_output_conditioning cmp_output_conditioning_i (.ref_clk, .reset_n,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .cmpResult,
		.cutoffOut, .eventOut, .irqOut);
	cmp_analog_model cmp_analog_model_i (.level, .cmpResult);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [19:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge ref_clk);
		regRead <= 1'b0;
	endtask
	task toggle();
		level <= 2'b11;
		wt(12);
		level <= 2'b00;
		wt(12);
	endtask
	task complete_run();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe is taken.
	always @(posedge ref_clk) begin
		if (rdSeen)
			chk(regRdData, expQ.pop_front());
		rdSeen <= regRead;
		if (eventOut[0] === 1'b1)
			evtCnt++;
		if (eventOut[1] === 1'b1)
			evtCnt++;
	end
	initial begin
		#40000;
		miscompares++;
		complete_run();
	end
	initial begin
		reset_n = 1'b0;
		{regWrite, regRead, rdSeen} = 3'b000;
		{regAddr, regWrData, level} = '0;
		{miscompares, n_compared, evtCnt} = '0;
		void'($urandom(32'hc031));
		wt(20);
		reset_n <= 1'b1;
		rd(FILTER_EDGE_ADDR, FILTER_EDGE_RST);
		rd(OUTPUT_CONTROL_ADDR, OUTPUT_CONTROL_RST);
		rd(IRQ_STATUS_ADDR, IRQ_STATUS_RST);
		rd(20'hf0350, READ_UNMAPPED);
		$display("reset values done");
		repeat (4) begin
			fe = 8'($urandom);
			wr(FILTER_EDGE_ADDR, fe);
			rd(FILTER_EDGE_ADDR, fe);
			fe = 8'($urandom);
			wr(OUTPUT_CONTROL_ADDR, fe);
			rd(OUTPUT_CONTROL_ADDR, fe & OUTPUT_CONTROL_WMASK);
		end
		$display("readback done");
		wr(OUTPUT_CONTROL_ADDR, 8'h33);
		wr(IRQ_MASK_ADDR, 8'h03);
		for (int m = 0; m < 4; m++) begin
			wr(FILTER_EDGE_ADDR, {m[1:0], 2'b00, m[1:0], 2'b00});
			wt(12);
			wr(IRQ_STATUS_ADDR, 8'h03);
			evtCnt = 0;
			toggle();
			chk(8'(evtCnt), m[1] ? 8'h04 : 8'h02);
			chk(8'(irqOut), 8'h01);
			rd(IRQ_STATUS_ADDR, 8'h03);
		end
		wr(IRQ_MASK_ADDR, 8'h00);
		wt(3);
		chk(8'(irqOut), 8'h00);
		wr(IRQ_STATUS_ADDR, 8'h03);
		rd(IRQ_STATUS_ADDR, 8'h00);
		wr(OUTPUT_CONTROL_ADDR, 8'h22);
		wr(IRQ_MASK_ADDR, 8'h03);
		evtCnt = 0;
		toggle();
		chk(8'(evtCnt), 8'h04);
		rd(IRQ_STATUS_ADDR, 8'h00);
		$display("edge and interrupt done");
		wr(OUTPUT_CONTROL_ADDR, 8'h66);
		level <= 2'b01;
		wt(12);
		chk(8'(cutoffOut), 8'h02);
		rd(MONITOR_ADDR, 8'h01);
		wr(OUTPUT_CONTROL_ADDR, 8'h44);
		wt(4);
		chk(8'(cutoffOut), 8'h00);
		level <= 2'b00;
		wr(OUTPUT_CONTROL_ADDR, 8'h22);
		$display("output path done");
		for (r = 1; r < 4; r++) begin
			p = (r == 1) ? 1 : ((r == 2) ? 8 : 32);
			wr(FILTER_EDGE_ADDR, {2'b00, r[1:0], 2'b00, r[1:0]});
			wt(4 * p + 12);
			// A glitch shorter than two sample periods never wins the vote.
			level <= 2'b11;
			wt(int'($urandom_range(2 * p, 1)));
			level <= 2'b00;
			wt(8 * p + 12);
			chk(8'(cutoffOut), 8'h00);
			level <= 2'b11;
			wt(6 * p + 12);
			chk(8'(cutoffOut), 8'h03);
			level <= 2'b00;
			wt(6 * p + 12);
			chk(8'(cutoffOut), 8'h00);
		end
		$display("filter rates done");
		reset_n <= 1'b0;
		wt(3);
		reset_n <= 1'b1;
		rd(FILTER_EDGE_ADDR, FILTER_EDGE_RST);
		rd(OUTPUT_CONTROL_ADDR, OUTPUT_CONTROL_RST);
		wt(2);
		$display("second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
